// ---- test/alarm_code_checker.sv ----
// port checker for the alarm code transmitter.
// assumes registered one-cycle ack and valid pulses.
`timescale 1ns/10ps
module alarm_code_checker
   import alarm_code_pkg::*;
#(
   parameter int REPS = MSG_REPS
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic frame_slot,
   input wire logic cbit_parity_mode,
   input wire logic alarm_bit_valid,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
   a_valid_single: assert property (alarm_bit_valid |=> !alarm_bit_valid) else $error("valid too long");
   a_valid_slot: assert property (alarm_bit_valid |-> $past(frame_slot, 3) && !$past(frame_slot, 4))
      else $error("valid not tied to slot");
   a_mode_gate: assert property (!cbit_parity_mode [*5] |-> !alarm_bit_valid) else $error("bit outside mode");
   a_code_pad: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == {IDX_CODE, 2'b00}
      |-> !wb_dat_o[7] && !wb_dat_o[0]) else $error("code pad bits set");
   a_dat_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("read data upper bits");
   a_irq_reset: assert property ($fell(sys_rst) |-> !irq) else $error("irq after reset");
endmodule
bind ds3_far_end_alarm_code_transmitter alarm_code_checker #(.REPS(REPS)) chk (.clk(clk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .frame_slot(frame_slot), .cbit_parity_mode(cbit_parity_mode),
   .alarm_bit_valid(alarm_bit_valid), .irq(irq));

// ---- test/frame_partner.sv ----
// remote terminal model: makes the frame slot pulses, collects alarm bits.
// assumes one design clock; slot high 3 cycles, low 3 cycles.
`timescale 1ns/10ps
module frame_partner (
   input wire logic clk,
   output logic frame_slot,
   input wire logic alarm_bit,
   input wire logic alarm_bit_valid,
   output logic [15:0] last16,
   output int nbits
);
   logic [2:0] ph = 3'h0;
   logic slot_q = 1'b0;
   logic [15:0] bits_q = 16'h0000;
   int cnt_q = 0;

   // free-running frame timing; first bit sent ends in bit 0
   always @(posedge clk) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      slot_q <= (ph < 3'h3);
      if (alarm_bit_valid === 1'b1) begin
         bits_q <= {alarm_bit, bits_q[15:1]};
         cnt_q <= cnt_q + 1;
      end
   end

   assign frame_slot = slot_q;
   assign last16 = bits_q;
   assign nbits = cnt_q;
endmodule

// ---- test/testbench.sv ----
// bench: register calls over classic Wishbone, message runs per gate setting.
// assumes the frame partner and the bound checker.
`timescale 1ns/10ps
module testbench;
   import alarm_code_pkg::*;
   localparam int R = 2;
   localparam int N = R * MSG_LEN;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic mode = 1'b1;
   logic [15:0] adr = 16'h0000;
   logic [31:0] wdat = 32'h00000000;
   logic [3:0] sel = 4'h0;
   logic [3:0] wsel = 4'hF;
   logic [31:0] rdat;
   logic ack, slot, abit, aval, irq;
   logic [15:0] last16;
   logic [7:0] q;
   int nbits, n0;
   int error_cnt = 0;
   int cmp_count = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   ds3_far_end_alarm_code_transmitter #(.REPS(R)) DUT (.clk(clk), .sys_rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .frame_slot(slot), .cbit_parity_mode(mode), .alarm_bit(abit),
      .alarm_bit_valid(aval), .irq(irq));
   frame_partner far (.clk(clk), .frame_slot(slot), .alarm_bit(abit), .alarm_bit_valid(aval),
      .last16(last16), .nbits(nbits));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= wsel;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      if (n >= 50) error_cnt++;
   endtask
   task automatic rd(input string what, input logic [13:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(what, {8'h00, q}, {8'h00, exp});
   endtask
   task automatic wait_bits(input int k);
      int n;
      n = 0;
      while (nbits < k && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) error_cnt++;
   endtask
   task automatic run(input logic [5:0] code, input logic [7:0] on, input logic exp_irq);
      bus(1'b1, IDX_CODE, {1'b0, code, 1'b0});
      bus(1'b1, IDX_CFG_STATUS, on | 8'h04);
      wait_bits(nbits + 1);
      bus(1'b1, IDX_CFG_STATUS, on | 8'h06);
      n0 = nbits;
      wait_bits(n0 + N - 1);
      rd("busy", IDX_CFG_STATUS, on | 8'h07);
      wait_bits(n0 + N);
      check("message", last16, {1'b0, code, 1'b0, 8'hFF});
      repeat (3) @(posedge clk);
      check("irq", {15'h0000, irq}, {15'h0000, exp_irq});
      rd("done", IDX_CFG_STATUS, on | 8'h0E);
      rd("flag clear", IDX_CFG_STATUS, on | 8'h06);
      check("irq low", {15'h0000, irq}, 16'h0000);
      $display("test message %h done", code);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      test_done;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd("cfg reset", IDX_CFG_STATUS, 8'h04);
      rd("op reset", IDX_OP_IRQ_EN, 8'h00);
      rd("unmapped", 14'h0000, 8'h00);
      bus(1'b1, IDX_OP_IRQ_EN, 8'hFF);
      rd("op mask", IDX_OP_IRQ_EN, 8'hDC);
      bus(1'b1, IDX_BLK_IRQ_EN, 8'hFF);
      rd("blk mask", IDX_BLK_IRQ_EN, 8'hC3);
      bus(1'b1, IDX_CODE, 8'hFF);
      rd("code pad", IDX_CODE, 8'h7E);
      wsel = 4'hE;
      bus(1'b1, IDX_CODE, 8'h00);
      wsel = 4'hF;
      rd("sel refused", IDX_CODE, 8'h7E);
      wait_bits(16);
      check("idle", last16, 16'hFFFF);
      $display("test registers done");
      run(6'h2A, 8'h10, 1'b1);
      wait_bits(n0 + N + 16);
      check("repeat", last16, 16'h54FF);
      bus(1'b1, IDX_CFG_STATUS, 8'h16);
      repeat (3) @(posedge clk);
      rd("no retrigger", IDX_CFG_STATUS, 8'h16);
      rd("evt status", IDX_EVT_STATUS, 8'h03);
      bus(1'b1, IDX_EVT_ENABLE, 8'h01);
      rd("evt enable", IDX_EVT_ENABLE, 8'h01);
      check("evt irq", {15'h0000, irq}, 16'h0001);
      bus(1'b1, IDX_EVT_CLEAR, 8'h03);
      bus(1'b1, IDX_EVT_ENABLE, 8'h00);
      rd("evt clear", IDX_EVT_STATUS, 8'h00);
      check("evt irq low", {15'h0000, irq}, 16'h0000);
      $display("test events done");
      bus(1'b1, IDX_OP_IRQ_EN, 8'h00);
      run(6'h15, 8'h10, 1'b0);
      bus(1'b1, IDX_OP_IRQ_EN, 8'h04);
      bus(1'b1, IDX_BLK_IRQ_EN, 8'h00);
      run(6'h3F, 8'h10, 1'b0);
      bus(1'b1, IDX_BLK_IRQ_EN, 8'h02);
      run(6'h00, 8'h00, 1'b0);
      @(posedge clk);
      mode <= 1'b0;
      repeat (6) @(posedge clk);
      n0 = nbits;
      repeat (30) @(posedge clk);
      check("mode off", 16'(nbits), 16'(n0));
      mode <= 1'b1;
      $display("test mode done");
      test_done;
   end
endmodule

// ---- verilog/alarm_code_if.sv ----
// link between the transmitter control and its bit serializer.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface alarm_code_if;
   import alarm_code_pkg::*;

   logic tick;
   logic load;
   logic run;
   logic [MSG_LEN-1:0] msg;
   logic line_bit;
   logic msg_end;

   modport ctrl (output tick, output load, output run, output msg, input line_bit, input msg_end);
   modport ser (input tick, input load, input run, input msg, output line_bit, output msg_end);
endinterface

// ---- verilog/alarm_code_pkg.sv ----
// constants for the far-end alarm code transmitter: register map, field
// positions, reset values and message framing.
// assumes byte-wide registers, each on one 32-bit word of the register bus.
package alarm_code_pkg;

   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_OP_IRQ_EN = 14'h0116;
   localparam logic [13:0] IDX_BLK_IRQ_EN = 14'h1104;
   localparam logic [13:0] IDX_CFG_STATUS = 14'h1131;
   localparam logic [13:0] IDX_CODE = 14'h1132;
   localparam logic [13:0] IDX_EVT_STATUS = 14'h1140;
   localparam logic [13:0] IDX_EVT_CLEAR = 14'h1141;
   localparam logic [13:0] IDX_EVT_ENABLE = 14'h1142;
   localparam int ADR_W = 16;
   localparam int IDX_LSB = 2;
   localparam int SEL_LANE = 0;

   // operation block interrupt enable fields
   localparam int OP_FRAMER_EN_BIT = 2;
   localparam logic [7:0] OP_IRQ_EN_RW = 8'hDC;
   localparam logic [7:0] OP_IRQ_EN_RST = 8'h00;

   // framer block interrupt enable fields
   localparam int BLK_TX_EN_BIT = 1;
   localparam logic [7:0] BLK_IRQ_EN_RW = 8'hC3;
   localparam logic [7:0] BLK_IRQ_EN_RST = 8'h00;

   // configuration and status fields
   localparam int CFG_BUSY_BIT = 0;
   localparam int CFG_TRIGGER_BIT = 1;
   localparam int CFG_TX_ON_BIT = 2;
   localparam int CFG_FLAG_BIT = 3;
   localparam int CFG_IRQ_ON_BIT = 4;
   localparam logic CFG_TX_ON_RST = 1'b1;

   // code register: word in bits 6..1, bits 0 and 7 read zero
   localparam int CODE_LSB = 1;
   localparam int CODE_W = 6;

   // own event status / clear / enable layout
   localparam int EVT_DONE_BIT = 0;
   localparam int EVT_START_BIT = 1;
   localparam int EVT_W = 2;

   // message framing
   localparam int MSG_LEN = 16;
   localparam int MSG_REPS = 10;
   localparam logic [7:0] MSG_ONES = 8'hFF;

endpackage

// ---- verilog/alarm_code_serializer.sv ----
// bit serializer: one message bit per frame tick, rightmost bit first.
// assumes tick is a one-cycle pulse per outbound frame.
`timescale 1ns/10ps
module alarm_code_serializer
   import alarm_code_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   alarm_code_if.ser lnk
);
   localparam int POS_W = $clog2(MSG_LEN);
   localparam logic [POS_W-1:0] LAST_POS = POS_W'(MSG_LEN - 1);

   logic [MSG_LEN-1:0] msg_q;
   logic [POS_W-1:0] idx_q;
   logic sending_q;

   ////////////////////////////////////////////////////////////////////////
   // message latch and bit position
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         msg_q <= '0;
         idx_q <= '0;
         sending_q <= 1'b0;
      end else if (!lnk.run) begin
         idx_q <= '0;
         sending_q <= 1'b0;
      end else if (lnk.load) begin
         msg_q <= lnk.msg;
         idx_q <= '0;
         sending_q <= 1'b1;
      end else if (lnk.tick && sending_q) begin
         idx_q <= idx_q + 1'b1; // R11
      end
   end

   // idle sends ones; the message repeats by index wrap
   assign lnk.line_bit = sending_q ? msg_q[idx_q] : 1'b1; // R12
   assign lnk.msg_end = lnk.run && sending_q && lnk.tick && !lnk.load && (idx_q == LAST_POS);
endmodule

// ---- verilog/ds3_far_end_alarm_code_transmitter.sv ----
// far-end alarm code transmitter: register file, trigger, repetition
// count, interrupt gating and frame-bit output.
// assumes a classic Wishbone master and frame pins from the framer core.
//
// Behaviour
// [R1] interrupt after the tenth message repetition
// [R2] operation block enable bit 2 gates all
// [R3] framer block enable bit 1 gates
// [R4] source enable is config bit 4
// [R5] start only on trigger rising edge
// [R6] software keeps enable set when triggering
// [R7] software clears trigger before next start
// [R8] send sixteen bits ten times, one/frame
// [R9] busy high during the ten repetitions
// [R10] keep resending message after the tenth
// [R11] ones, zero, code, zero; rightmost first
// [R12] idle pattern of ones when enabled
// [R13] code in bits 6..1, others zero
// [R14] only in C-bit parity format
// [R15] done flag set, cleared on read
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
module ds3_far_end_alarm_code_transmitter
   import alarm_code_pkg::*;
#(
   parameter int REPS = MSG_REPS
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic frame_slot,
   input wire logic cbit_parity_mode,
   output logic alarm_bit,
   output logic alarm_bit_valid,
   output logic irq
);
   localparam int REP_W = $clog2(REPS + 1);

   alarm_code_if lnk();

   logic [7:0] op_irq_en_q;
   logic [7:0] blk_irq_en_q;
   logic irq_on_q;
   logic tx_on_q;
   logic trigger_q;
   logic trigger_prev_q;
   logic busy_q;
   logic done_flag_q;
   logic [CODE_W-1:0] code_q;
   logic [EVT_W-1:0] evt_status_q;
   logic [EVT_W-1:0] evt_enable_q;
   logic [REP_W-1:0] rep_q;
   logic slot_s1_q;
   logic slot_s2_q;
   logic slot_s3_q;
   logic mode_s1_q;
   logic mode_s2_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic alarm_bit_q;
   logic valid_q;
   logic irq_q;

   logic req;
   logic wr;
   logic rd;
   logic [13:0] idx;
   logic frame_tick;
   logic active;
   logic start;
   logic done_evt;
   logic cfg_read;
   logic [7:0] cfg_rd;
   logic [7:0] rd_byte;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic wr_op;
   logic wr_blk;
   logic wr_cfg;
   logic wr_code;
   logic wr_evt_clr;
   logic wr_evt_en;
   logic trig_rise;
   logic last_rep;
   logic src_irq;
   logic evt_irq;
   logic irq_gate;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = req && wb_we_i && wb_sel_i[SEL_LANE];
   assign rd = req && !wb_we_i;
   assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
   assign cfg_read = rd && (idx == IDX_CFG_STATUS);

   // write strobes, one per register except the read-only event status
   assign wr_op = wr && (idx == IDX_OP_IRQ_EN);
   assign wr_blk = wr && (idx == IDX_BLK_IRQ_EN);
   assign wr_cfg = wr && (idx == IDX_CFG_STATUS);
   assign wr_code = wr && (idx == IDX_CODE);
   assign wr_evt_clr = wr && (idx == IDX_EVT_CLEAR);
   assign wr_evt_en = wr && (idx == IDX_EVT_ENABLE);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         slot_s1_q <= 1'b0;
         slot_s2_q <= 1'b0;
         slot_s3_q <= 1'b0;
      end else begin
         slot_s1_q <= frame_slot;
         slot_s2_q <= slot_s1_q;
         slot_s3_q <= slot_s2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
      end else begin
         mode_s1_q <= cbit_parity_mode;
         mode_s2_q <= mode_s1_q;
      end
   end

   // one tick per outbound frame alarm bit slot
   assign frame_tick = slot_s2_q && !slot_s3_q;
   assign active = tx_on_q && mode_s2_q; // R14

   ////////////////////////////////////////////////////////////////////////
   // interrupt enable registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         op_irq_en_q <= OP_IRQ_EN_RST;
      end else if (wr_op) begin
         op_irq_en_q <= wb_dat_i[7:0] & OP_IRQ_EN_RW;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blk_irq_en_q <= BLK_IRQ_EN_RST;
      end else if (wr_blk) begin
         blk_irq_en_q <= wb_dat_i[7:0] & BLK_IRQ_EN_RW;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration bits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_on_q <= 1'b0;
         tx_on_q <= CFG_TX_ON_RST;
         trigger_q <= 1'b0;
      end else if (wr_cfg) begin
         irq_on_q <= wb_dat_i[CFG_IRQ_ON_BIT]; // R4
         tx_on_q <= wb_dat_i[CFG_TX_ON_BIT];
         trigger_q <= wb_dat_i[CFG_TRIGGER_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         code_q <= '0;
      end else if (wr_code) begin
         code_q <= wb_dat_i[CODE_LSB +: CODE_W]; // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trigger_prev_q <= 1'b0;
      end else begin
         trigger_prev_q <= trigger_q;
      end
   end

   // a level held high starts nothing further
   assign trig_rise = trigger_q && !trigger_prev_q;
   assign start = trig_rise && active; // R5

   ////////////////////////////////////////////////////////////////////////
   // repetition count and busy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rep_q <= '0;
      end else if (start || !active) begin
         rep_q <= '0;
      end else if (lnk.msg_end && busy_q) begin
         rep_q <= rep_q + 1'b1; // R8
      end
   end

   assign last_rep = (rep_q == REP_W'(REPS - 1));
   assign done_evt = busy_q && lnk.msg_end && last_rep; // R1

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else if (start) begin
         busy_q <= 1'b1; // R9
      end else if (done_evt || !active) begin
         busy_q <= 1'b0; // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serializer control; message keeps repeating after the count ends
   assign lnk.tick = frame_tick;
   assign lnk.load = start;
   assign lnk.run = active; // R10
   assign lnk.msg = {1'b0, code_q, 1'b0, MSG_ONES}; // R11

   alarm_code_serializer u_ser (
      .clk(clk),
      .sys_rst(sys_rst),
      .lnk(lnk.ser)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alarm_bit_q <= 1'b1;
         valid_q <= 1'b0;
      end else begin
         alarm_bit_q <= lnk.line_bit; // R12
         valid_q <= active && frame_tick; // R14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // done flag: set wins over the read clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         done_flag_q <= 1'b0;
      end else if (done_evt) begin
         done_flag_q <= 1'b1; // R15
      end else if (cfg_read) begin
         done_flag_q <= 1'b0; // R15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event status, clear and enable
   assign evt_set = {start, done_evt};
   assign evt_clr = wr_evt_clr ? wb_dat_i[EVT_W-1:0] : '0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_status_q <= '0;
      end else begin
         evt_status_q <= evt_set | (evt_status_q & ~evt_clr);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_enable_q <= '0;
      end else if (wr_evt_en) begin
         evt_enable_q <= wb_dat_i[EVT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt output, gated at operation and framer block level
   assign src_irq = irq_on_q && done_flag_q; // R4
   assign evt_irq = |(evt_status_q & evt_enable_q);
   assign irq_gate = op_irq_en_q[OP_FRAMER_EN_BIT] // R2
      && blk_irq_en_q[BLK_TX_EN_BIT]; // R3

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_gate && (src_irq || evt_irq); // R1
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      cfg_rd = '0;
      cfg_rd[CFG_BUSY_BIT] = busy_q;
      cfg_rd[CFG_TRIGGER_BIT] = trigger_q;
      cfg_rd[CFG_TX_ON_BIT] = tx_on_q;
      cfg_rd[CFG_FLAG_BIT] = done_flag_q;
      cfg_rd[CFG_IRQ_ON_BIT] = irq_on_q;
   end

   always_comb begin
      rd_byte = '0;
      unique case (idx)
         IDX_OP_IRQ_EN: begin
            rd_byte = op_irq_en_q;
         end
         IDX_BLK_IRQ_EN: begin
            rd_byte = blk_irq_en_q;
         end
         IDX_CFG_STATUS: begin
            rd_byte = cfg_rd;
         end
         IDX_CODE: begin
            rd_byte[CODE_LSB +: CODE_W] = code_q; // R13
         end
         IDX_EVT_STATUS: begin
            rd_byte[EVT_W-1:0] = evt_status_q;
         end
         IDX_EVT_ENABLE: begin
            rd_byte[EVT_W-1:0] = evt_enable_q;
         end
         default: begin
            rd_byte = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer: one wait state, unmapped reads return zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= req;
         dat_q <= rd ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign alarm_bit = alarm_bit_q;
   assign alarm_bit_valid = valid_q;
   assign irq = irq_q;
endmodule
